// file: common/rmd_defs.vh
// Register map, field layout and constants for the radio MAC packet DMA setup block
// How it works
// RQ1 - Receive bytes go to memory from rx pointer
// RQ2 - Rx pointer register unchanged during reception
// RQ3 - Rx pointer write arms one receive buffer
// RQ4 - Received-packet interrupt consumes the armed buffer
// RQ5 - Sync without buffer: packet treated bad header
// RQ6 - Sync without buffer also sets overrun flag
// RQ7 - Transmit fetches bytes from tx source pointer
// RQ8 - Poll reply fetches bytes from poll pointer
// RQ9 - Poll pointer write arms immediate reply
// RQ10 - Tx length bits 14:0 count sent bytes
// RQ11 - Standard mode uses only low seven bits
// RQ12 - Software writes length before source pointers
// RQ13 - Seven-bit sequence copy checks acknowledgements
// RQ14 - Sequence number written before pointers when acked
// RQ15 - Sequence number may stay for unacked sends
// RQ16 - Internal working address walks, registers stay
// RQ17 - Reads return last write, reserved zero; CTRL bits 2:1 read back the sequencer state and STATUS reads the event flags instead
`ifndef RMD_DEFS_VH
`define RMD_DEFS_VH
`define RMD_OFS_RX_PTR 8'h80
`define RMD_OFS_TX_PTR 8'h84
`define RMD_OFS_POLL_PTR 8'h88
`define RMD_OFS_TX_LEN 8'h8C
`define RMD_OFS_TX_SEQ 8'h90
`define RMD_OFS_STATUS 8'hA0
`define RMD_OFS_MASK 8'hA4
`define RMD_OFS_CTRL 8'hA8
`define RMD_TXLEN_W 15
`define RMD_TXLEN_STD_W 7
`define RMD_SEQ_W 7
`define RMD_ST_W 4
`define RMD_ST_OVR 0
`define RMD_ST_RXDONE 1
`define RMD_ST_TXDONE 2
`define RMD_ST_BADHDR 3
`define RMD_CTRL_STD 0
`define RMD_RESET_VAL 32'h00000000
`endif

// file: hdl/rmd_apb_slave.v
// APB slave register file of the packet DMA setup block
`timescale 1ns/1ps
`include "rmd_defs.vh"
module rmd_apb_slave (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_i,
   // APB
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // Register values
   output reg [31:0] rx_ptr_o,
   output reg [31:0] tx_ptr_o,
   output reg [31:0] poll_ptr_o,
   output reg [`RMD_TXLEN_W-1:0] tx_len_o,
   output reg [`RMD_SEQ_W-1:0] seq_o,
   output reg [`RMD_ST_W-1:0] mask_o,
   output reg std_mode_o,
   // Write strobes and status access
   output wire rx_ptr_wr_o,
   output wire tx_ptr_wr_o,
   output wire poll_ptr_wr_o,
   output wire status_rd_o,
   input wire [`RMD_ST_W-1:0] status_i,
   input wire [1:0] state_i
);
   reg rd_wait_r;
   wire access = psel_i & penable_i;
   wire wr = access & pwrite_i;
   // Read data come from a flop, so a read waits one cycle for them
   wire rd_first = access & ~pwrite_i & ~rd_wait_r;
   reg mapped;
   reg [31:0] rd_nxt;
   assign pready_o = pwrite_i | rd_wait_r;
   // Unmapped offsets answer with an error rather than silently aliasing
   assign pslverr_o = access & ~mapped;
   assign rx_ptr_wr_o = wr & (paddr_i == `RMD_OFS_RX_PTR);
   assign tx_ptr_wr_o = wr & (paddr_i == `RMD_OFS_TX_PTR);
   assign poll_ptr_wr_o = wr & (paddr_i == `RMD_OFS_POLL_PTR);
   // Clear only where the read data are captured, so no event is lost between
   assign status_rd_o = rd_first & (paddr_i == `RMD_OFS_STATUS);
   always @* begin
      mapped = 1'b1;
      rd_nxt = 32'h00000000;
      case (paddr_i)
         `RMD_OFS_RX_PTR: rd_nxt = rx_ptr_o; // RQ17
         `RMD_OFS_TX_PTR: rd_nxt = tx_ptr_o;
         `RMD_OFS_POLL_PTR: rd_nxt = poll_ptr_o;
         `RMD_OFS_TX_LEN: rd_nxt = {17'h00000, tx_len_o};
         `RMD_OFS_TX_SEQ: rd_nxt = {25'h0000000, seq_o};
         `RMD_OFS_STATUS: rd_nxt = {28'h0000000, status_i};
         `RMD_OFS_MASK: rd_nxt = {28'h0000000, mask_o};
         `RMD_OFS_CTRL: rd_nxt = {29'h00000000, state_i, std_mode_o};
         default: mapped = 1'b0;
      endcase
   end
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         rx_ptr_o <= `RMD_RESET_VAL;
         tx_ptr_o <= `RMD_RESET_VAL;
         poll_ptr_o <= `RMD_RESET_VAL;
         tx_len_o <= 15'h0000;
         seq_o <= 7'h00;
         mask_o <= 4'h0;
         std_mode_o <= 1'b0;
         prdata_o <= 32'h00000000;
         rd_wait_r <= 1'b0;
      end else begin
         rd_wait_r <= rd_first;
         if (rd_first)
            prdata_o <= rd_nxt;
         if (wr) begin
            case (paddr_i)
               `RMD_OFS_RX_PTR: rx_ptr_o <= pwdata_i;
               `RMD_OFS_TX_PTR: tx_ptr_o <= pwdata_i;
               `RMD_OFS_POLL_PTR: poll_ptr_o <= pwdata_i;
               `RMD_OFS_TX_LEN: tx_len_o <= pwdata_i[`RMD_TXLEN_W-1:0]; // RQ10
               `RMD_OFS_TX_SEQ: seq_o <= pwdata_i[`RMD_SEQ_W-1:0]; // RQ13
               `RMD_OFS_MASK: mask_o <= pwdata_i[`RMD_ST_W-1:0];
               `RMD_OFS_CTRL: std_mode_o <= pwdata_i[`RMD_CTRL_STD];
               default: std_mode_o <= std_mode_o;
            endcase
         end
      end
   end
endmodule // rmd_apb_slave

// file: hdl/rmd_dma.v
// Packet DMA setup: registers, byte mover and buffer arming for the radio MAC
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "rmd_defs.vh"
module rmd_dma (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_i,
   // APB
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // Sequencer: receive side
   input wire rx_sync_i,
   input wire rx_data_valid_i,
   input wire [7:0] rx_data_i,
   input wire rx_done_i,
   input wire rx_restart_i,
   output wire rx_data_ready_o,
   output reg rx_bad_header_o,
   output reg packet_received_interrupt_o,
   // Sequencer: transmit side
   input wire tx_start_i,
   input wire poll_request_i,
   output wire tx_data_valid_o,
   output reg [7:0] tx_data_o,
   input wire tx_data_ready_i,
   output reg tx_done_o,
   output wire poll_armed_o,
   output wire [`RMD_TXLEN_W-1:0] tx_count_o,
   output wire [`RMD_SEQ_W-1:0] outgoing_sequence_number_o,
   // Memory byte port
   output reg mem_req_o,
   output reg mem_we_o,
   output reg [31:0] mem_addr_o,
   output reg [7:0] mem_wdata_o,
   input wire mem_ack_i,
   input wire [7:0] mem_rdata_i,
   // Interrupt
   output wire irq_o
);
   localparam ST_IDLE = 2'd0;
   localparam ST_RX = 2'd1;
   localparam ST_TX = 2'd2;
   localparam ST_TXOUT = 2'd3;

   wire [31:0] rx_ptr;
   wire [31:0] tx_ptr;
   wire [31:0] poll_ptr;
   wire [`RMD_TXLEN_W-1:0] tx_len;
   wire [`RMD_ST_W-1:0] mask;
   wire [`RMD_ST_W-1:0] status;
   wire std_mode;
   wire rx_ptr_wr;
   wire tx_ptr_wr;
   wire poll_ptr_wr;
   wire status_rd;
   reg [1:0] state_r;
   reg [31:0] work_addr_r;
   reg [`RMD_TXLEN_W-1:0] remain_r;
   reg buf_armed_r;
   reg poll_armed_r;
   reg rx_ok_r;
   reg rewind_r;
   reg overrun_ev;
   reg [`RMD_ST_W-1:0] events;
   wire rx_end;
   wire poll_go;

   rmd_apb_slave u_regs (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .prdata_o(prdata_o),
      .pready_o(pready_o),
      .pslverr_o(pslverr_o),
      .rx_ptr_o(rx_ptr),
      .tx_ptr_o(tx_ptr),
      .poll_ptr_o(poll_ptr),
      .tx_len_o(tx_len),
      .seq_o(outgoing_sequence_number_o),
      .mask_o(mask),
      .std_mode_o(std_mode),
      .rx_ptr_wr_o(rx_ptr_wr),
      .tx_ptr_wr_o(tx_ptr_wr),
      .poll_ptr_wr_o(poll_ptr_wr),
      .status_rd_o(status_rd),
      .status_i(status),
      .state_i(state_r)
   );

   rmd_irq u_irq (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .event_i(events),
      .status_rd_i(status_rd),
      .mask_i(mask),
      .status_o(status),
      .irq_o(irq_o)
   );

   // Length actually used by the transmit sequence
   function [`RMD_TXLEN_W-1:0] eff_len;
      input [`RMD_TXLEN_W-1:0] len;
      input std;
      begin
         if (std)
            eff_len = {8'h00, len[`RMD_TXLEN_STD_W-1:0]}; // RQ11
         else
            eff_len = len; // RQ10
      end
   endfunction

   assign tx_count_o = eff_len(tx_len, std_mode);
   assign poll_armed_o = poll_armed_r;
   // Receive bytes are taken only while the memory write is idle and no
   // rewind is asked for, since a byte taken in a rewind cycle would be lost
   assign rx_data_ready_o = (state_r == ST_RX) & ~mem_req_o & ~rx_restart_i;
   // Packet end counts only where no byte, write or rewind competes with it
   assign rx_end = (state_r == ST_RX) & ~mem_req_o & ~rx_restart_i & ~rx_data_valid_i &
      rx_done_i & rx_ok_r;
   // A normal send outranks a poll reply, so only a started reply disarms
   assign poll_go = (state_r == ST_IDLE) & ~rx_sync_i & ~tx_start_i & poll_request_i &
      poll_armed_r;
   assign tx_data_valid_o = (state_r == ST_TXOUT);

   always @* begin
      events = 4'h0;
      events[`RMD_ST_OVR] = overrun_ev;
      events[`RMD_ST_RXDONE] = packet_received_interrupt_o;
      events[`RMD_ST_TXDONE] = tx_done_o;
      events[`RMD_ST_BADHDR] = rx_bad_header_o;
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         work_addr_r <= 32'h00000000;
         remain_r <= 15'h0000;
         buf_armed_r <= 1'b0;
         poll_armed_r <= 1'b0;
         rx_ok_r <= 1'b0;
         rewind_r <= 1'b0;
         overrun_ev <= 1'b0;
         rx_bad_header_o <= 1'b0;
         packet_received_interrupt_o <= 1'b0;
         tx_done_o <= 1'b0;
         tx_data_o <= 8'h00;
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_addr_o <= 32'h00000000;
         mem_wdata_o <= 8'h00;
      end else begin
         overrun_ev <= 1'b0;
         rx_bad_header_o <= 1'b0;
         packet_received_interrupt_o <= 1'b0;
         tx_done_o <= 1'b0;
         // Consumption on completion; a pointer write in the same cycle rearms
         if (rx_ptr_wr)
            buf_armed_r <= 1'b1; // RQ3
         else if (rx_end)
            buf_armed_r <= 1'b0; // RQ4
         if (poll_ptr_wr)
            poll_armed_r <= 1'b1; // RQ9
         else if (poll_go)
            poll_armed_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (rx_sync_i) begin
                  if (buf_armed_r) begin
                     work_addr_r <= rx_ptr; // RQ16
                     rx_ok_r <= 1'b1;
                     state_r <= ST_RX;
                  end else begin
                     rx_bad_header_o <= 1'b1; // RQ5
                     overrun_ev <= 1'b1; // RQ6
                  end
               end else if (tx_start_i | (poll_request_i & poll_armed_r)) begin
                  // Pointer registers are only read here, never written back
                  work_addr_r <= tx_start_i ? tx_ptr : poll_ptr; // RQ7 RQ8
                  remain_r <= eff_len(tx_len, std_mode);
                  if (eff_len(tx_len, std_mode) == 15'h0000)
                     tx_done_o <= 1'b1;
                  else begin
                     mem_req_o <= 1'b1;
                     mem_we_o <= 1'b0;
                     mem_addr_o <= tx_start_i ? tx_ptr : poll_ptr;
                     state_r <= ST_TX;
                  end
               end
            end
            ST_RX: begin
               if (mem_req_o) begin
                  if (mem_ack_i) begin
                     mem_req_o <= 1'b0;
                     rewind_r <= 1'b0;
                     // A rewind that met a pending write lands after it
                     if (rewind_r | rx_restart_i)
                        work_addr_r <= rx_ptr; // RQ2
                     else
                        work_addr_r <= work_addr_r + 32'h00000001; // RQ16
                  end else if (rx_restart_i)
                     rewind_r <= 1'b1;
               end else if (rx_restart_i) begin
                  // Failed checksum: start over from the unchanged pointer
                  work_addr_r <= rx_ptr; // RQ2
               end else if (rx_data_valid_i) begin
                  mem_req_o <= 1'b1; // RQ1
                  mem_we_o <= 1'b1;
                  mem_addr_o <= work_addr_r;
                  mem_wdata_o <= rx_data_i;
               end else if (rx_done_i) begin
                  packet_received_interrupt_o <= 1'b1; // RQ4
                  rx_ok_r <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
            ST_TX: begin
               if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  tx_data_o <= mem_rdata_i;
                  work_addr_r <= work_addr_r + 32'h00000001;
                  remain_r <= remain_r - 15'h0001;
                  state_r <= ST_TXOUT;
               end
            end
            ST_TXOUT: begin
               if (tx_data_ready_i) begin
                  if (remain_r == 15'h0000) begin
                     tx_done_o <= 1'b1;
                     state_r <= ST_IDLE;
                  end else begin
                     mem_req_o <= 1'b1; // RQ7 RQ8
                     mem_we_o <= 1'b0;
                     mem_addr_o <= work_addr_r;
                     state_r <= ST_TX;
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule // rmd_dma

// file: hdl/rmd_irq.v
// Sticky event status with read-to-clear and masked interrupt output
`timescale 1ns/1ps
`include "rmd_defs.vh"
module rmd_irq (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_i,
   // Events and access
   input wire [`RMD_ST_W-1:0] event_i,
   input wire status_rd_i,
   input wire [`RMD_ST_W-1:0] mask_i,
   // Status and interrupt
   output reg [`RMD_ST_W-1:0] status_o,
   output wire irq_o
);
   assign irq_o = |(status_o & mask_i);
   always @(posedge core_clk_i) begin
      if (rst_i)
         status_o <= 4'h0;
      // A new event in the clearing read's cycle survives
      else if (status_rd_i)
         status_o <= event_i;
      else
         status_o <= status_o | event_i;
   end
endmodule // rmd_irq

// file: test/rmd_dma_properties.sv
// Port-level assertions for the packet DMA setup block
`timescale 1ns/1ps
`include "rmd_defs.vh"
module rmd_dma_props (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_i,
   // APB
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   // Sequencer
   input wire rx_data_valid_i,
   input wire [7:0] rx_data_i,
   input wire rx_data_ready_o,
   input wire rx_bad_header_o,
   input wire packet_received_interrupt_o,
   input wire tx_data_valid_o,
   input wire [7:0] tx_data_o,
   input wire tx_data_ready_i,
   input wire poll_armed_o,
   input wire [6:0] outgoing_sequence_number_o,
   // Memory
   input wire mem_req_o,
   input wire mem_we_o,
   input wire [31:0] mem_addr_o,
   input wire [7:0] mem_wdata_o,
   input wire mem_ack_i,
   input wire [7:0] mem_rdata_i
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   wire apb_wr = psel_i && penable_i && pwrite_i;
   rx_byte_a: assert property (rx_data_valid_i && rx_data_ready_o |=>
      mem_req_o && mem_we_o && mem_wdata_o == $past(rx_data_i)) else $error("rx byte");
   mem_hold_a: assert property (mem_req_o && !mem_ack_i |=>
      mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o)) else $error("mem hold");
   tx_fetch_a: assert property (mem_req_o && mem_ack_i && !mem_we_o |=>
      tx_data_valid_o && tx_data_o == $past(mem_rdata_i)) else $error("tx fetch");
   tx_hold_a: assert property (tx_data_valid_o && !tx_data_ready_i |=>
      tx_data_valid_o && $stable(tx_data_o)) else $error("tx hold");
   bad_pulse_a: assert property ($rose(rx_bad_header_o) |=> !rx_bad_header_o)
      else $error("bad header pulse");
   rx_done_a: assert property (packet_received_interrupt_o |=>
      !packet_received_interrupt_o) else $error("rx done pulse");
   seq_copy_a: assert property (apb_wr && paddr_i == `RMD_OFS_TX_SEQ |=>
      outgoing_sequence_number_o == $past(pwdata_i[6:0])) else $error("seq copy");
   poll_arm_a: assert property (apb_wr && paddr_i == `RMD_OFS_POLL_PTR |=>
      poll_armed_o) else $error("poll arm");
endmodule // rmd_dma_props

// file: test/rmd_mem_model.sv
// Byte-wide system memory answering the DMA after a random wait
`timescale 1ns/1ps
module rmd_mem_model (
   // Clock
   input wire core_clk_i,
   // Byte port
   input wire req_i,
   input wire we_i,
   input wire [31:0] addr_i,
   input wire [7:0] wdata_i,
   output reg ack_o,
   output reg [7:0] rdata_o
);
   reg [7:0] mem [0:255];
   integer seed = 15;
   integer wait_cnt = 0;
   initial ack_o = 1'b0;
   initial rdata_o = 8'hA5;
   // Read data toggles outside an answer so a stale byte never looks fresh
   always @(posedge core_clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
         if (wait_cnt == 0) begin
            ack_o <= 1'b1;
            wait_cnt <= {$random(seed)} % 3;
            if (we_i) mem[addr_i[7:0]] <= wdata_i;
            else rdata_o <= mem[addr_i[7:0]];
         end else
            wait_cnt <= wait_cnt - 1;
      end
   end
endmodule // rmd_mem_model

// file: test/tb_radio_mac_packet_dma_setup.sv
// Self-checking bench for the packet DMA setup block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("BAD %0t %h %h", $time, a, b); end end
`define WAITE(c) begin n = 0; do begin @(posedge core_clk_i); n++; end \
   while (!(c) && n < 200); if (n >= 200) begin bad_count++; print_verdict; end end
module tb_radio_mac_packet_dma_setup;
   logic core_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
   logic rx_sync_i = 0, rx_data_valid_i = 0, rx_done_i = 0, rx_restart_i = 0;
   logic tx_start_i = 0, poll_request_i = 0, tx_data_ready_i = 0;
   logic [7:0] paddr_i = 0, rx_data_i = 0;
   logic [31:0] pwdata_i = 0, rd, d;
   wire [31:0] prdata_o, mem_addr_o;
   wire [7:0] tx_data_o, mem_wdata_o, mem_rdata_i;
   wire [14:0] tx_count_o;
   wire [6:0] outgoing_sequence_number_o;
   wire pready_o, pslverr_o, rx_data_ready_o, rx_bad_header_o, packet_received_interrupt_o;
   wire tx_data_valid_o, tx_done_o, poll_armed_o, mem_req_o, mem_we_o, mem_ack_i, irq_o;
   integer seed = 15, bad_count = 0, total_checks = 0, i, n;
   logic [7:0] q[$], got[$];
   logic [7:0] ofs [0:4] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90};
   logic [31:0] msk [0:4] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00007FFF,
      32'h0000007F};
   rmd_dma u_dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_sync_i(rx_sync_i),
      .rx_data_valid_i(rx_data_valid_i), .rx_data_i(rx_data_i), .rx_done_i(rx_done_i),
      .rx_restart_i(rx_restart_i), .rx_data_ready_o(rx_data_ready_o),
      .rx_bad_header_o(rx_bad_header_o),
      .packet_received_interrupt_o(packet_received_interrupt_o),
      .tx_start_i(tx_start_i), .poll_request_i(poll_request_i),
      .tx_data_valid_o(tx_data_valid_o), .tx_data_o(tx_data_o),
      .tx_data_ready_i(tx_data_ready_i), .tx_done_o(tx_done_o), .poll_armed_o(poll_armed_o),
      .tx_count_o(tx_count_o), .outgoing_sequence_number_o(outgoing_sequence_number_o),
      .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
      .irq_o(irq_o));
   rmd_mem_model u_mem (.core_clk_i(core_clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   initial forever #2 core_clk_i = ~core_clk_i;
   // Random back-pressure from the transmit queue
   always @(posedge core_clk_i) tx_data_ready_i <= ($random(seed) % 2) != 0;
   always @(posedge core_clk_i) if (tx_data_valid_o && tx_data_ready_i) got.push_back(tx_data_o);
   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel_i <= 1;
      penable_i <= 0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge core_clk_i);
      penable_i <= 1;
      `WAITE(pready_o)
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
      @(posedge core_clk_i);
   endtask
   task sync(input logic e);
      rx_sync_i <= 1;
      @(posedge core_clk_i);
      rx_sync_i <= 0;
      @(posedge core_clk_i);
      `CHK(rx_bad_header_o, e)
   endtask
   task rx_send(input integer cnt);
      q.delete();
      rx_data_valid_i <= 1;
      for (i = 0; i < cnt; i++) begin
         d = $random(seed);
         rx_data_i <= d[7:0];
         q.push_back(d[7:0]);
         `WAITE(rx_data_ready_o)
      end
      rx_data_valid_i <= 0;
   endtask
   task tx_prep(input logic [7:0] base);
      q.delete();
      got.delete();
      for (i = 0; i < 3; i++) begin
         d = $random(seed);
         u_mem.mem[base + i] = d[7:0];
         q.push_back(d[7:0]);
      end
   endtask
   task tx_chk;
      `CHK(got.size(), 3)
      for (i = 0; i < 3; i++) `CHK(got[i], q[i])
   endtask
   initial begin
      repeat (3) @(posedge core_clk_i);
      rst_i <= 0;
      for (i = 0; i < 5; i++) begin
         apb(0, ofs[i], 0);
         `CHK(rd, 32'h00000000)
      end
      apb(1, 8'hA4, 32'h00000001);
      sync(1);
      // The status flag lands one edge after the overrun pulse
      @(posedge core_clk_i);
      `CHK(irq_o, 1'b1)
      apb(0, 8'hA0, 0);
      `CHK(rd[0], 1'b1)
      `CHK(irq_o, 1'b0)
      apb(0, 8'h40, 0);
      `CHK({err, rd}, 33'h100000000)
      for (i = 1; i < 5; i++) begin
         d = $random(seed);
         apb(1, ofs[i], d);
         apb(0, ofs[i], 0);
         `CHK(rd, d & msk[i])
      end
      `CHK(outgoing_sequence_number_o, d[6:0])
      apb(1, 8'h80, 32'h00000010);
      sync(0);
      rx_send(2);
      // Rewind while the second byte is still being written
      rx_restart_i <= 1;
      @(posedge core_clk_i);
      rx_restart_i <= 0;
      rx_send(4);
      rx_done_i <= 1;
      `WAITE(packet_received_interrupt_o)
      rx_done_i <= 0;
      for (i = 0; i < 4; i++) `CHK(u_mem.mem[8'h10 + i], q[i])
      apb(0, 8'h80, 0);
      `CHK(rd, 32'h00000010)
      sync(1);
      tx_prep(8'h40);
      apb(1, 8'h8C, 32'h00000003);
      apb(1, 8'h90, 32'h00000055);
      apb(1, 8'h84, 32'h00000040);
      tx_start_i <= 1;
      @(posedge core_clk_i);
      tx_start_i <= 0;
      `WAITE(tx_done_o)
      tx_chk;
      `CHK(tx_count_o, 15'h0003)
      apb(0, 8'h84, 0);
      `CHK(rd, 32'h00000040)
      // Overrun, receive done, transmit done and bad header since the last read
      apb(0, 8'hA0, 0);
      `CHK(rd, 32'h0000000F)
      apb(1, 8'hA8, 32'h00000001);
      apb(1, 8'h8C, 32'h00007F83);
      `CHK(tx_count_o, 15'h0003)
      tx_prep(8'h60);
      apb(1, 8'h88, 32'h00000060);
      poll_request_i <= 1;
      @(posedge core_clk_i);
      poll_request_i <= 0;
      `WAITE(tx_done_o)
      tx_chk;
      `CHK(poll_armed_o, 1'b0)
      `CHK(outgoing_sequence_number_o, 7'h55)
      print_verdict;
   end
endmodule // tb_radio_mac_packet_dma_setup
bind rmd_dma rmd_dma_props u_props (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .rx_data_valid_i(rx_data_valid_i), .rx_data_i(rx_data_i),
   .rx_data_ready_o(rx_data_ready_o), .rx_bad_header_o(rx_bad_header_o),
   .packet_received_interrupt_o(packet_received_interrupt_o),
   .tx_data_valid_o(tx_data_valid_o), .tx_data_o(tx_data_o),
   .tx_data_ready_i(tx_data_ready_i), .poll_armed_o(poll_armed_o),
   .outgoing_sequence_number_o(outgoing_sequence_number_o),
   .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
   .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
